// File: card_clock_common.sv
// Behaviour
// RULE_01: Two-bit ratio code: 00 output low, 01 undivided, 10 half, 11 quarter.
// RULE_02: Reference clock input accepted up to 40 MHz ahead of the divider.
// RULE_03: Host picks a ratio keeping the card clock at or below 20 MHz.
// RULE_04: Output taken from the last divider flip-flop, giving 50% duty cycle.
// RULE_05: New ratio reaches the output within four reference pulses; host waits for it.
// RULE_06: At ratio 1 duty holds only for input duty between 46% and 56%.
// RULE_07: Edge slope selectable slow or fast through the command, for any ratio.
// RULE_08: Slope changes on the fly; same command drives card reset from bit b4.
// RULE_09: Clock programming sits in bits b2 and b3 of the serial command byte.
// RULE_10: Command latched and settings updated only when chip select rises.
// RULE_11: MSB first; bits b7 to b5 form an address checked against the select pin.
// RULE_12: After reset the card clock stays low until a valid ratio is latched.
`timescale 1ns/1ps
package card_clock_pkg;
    typedef enum logic [1:0] {
        RATIO_OFF = 2'h0,
        RATIO_DIV1 = 2'h1,
        RATIO_DIV2 = 2'h2,
        RATIO_DIV4 = 2'h3
    } ratio_t;
    localparam int CLK_SYS_MHZ = 200;
    localparam int REF_MAX_MHZ = 40;
    localparam int CARD_MAX_MHZ = 20;
    // Sampling a 40 MHz reference at 200 MHz gives at least this many samples per period
    localparam int SAMPLES_PER_REF = CLK_SYS_MHZ / REF_MAX_MHZ;
    localparam int DUTY_MIN_PCT = 46;
    localparam int DUTY_MAX_PCT = 56;
    localparam int MAX_LAG_PULSES = 4;
    localparam int SLOPE_BIT = 1;
    localparam int RATIO_LSB = 2;
    localparam int RESET_BIT = 4;
    localparam int ADDR_LSB = 5;
    localparam logic [1:0] ADDR_HIGH = 2'h0;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [2:0] ADDR_DONE_CNT = 3'h2;
    localparam logic [2:0] BYTE_DONE_CNT = 3'h7;
endpackage

module sync_two_stage #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// File: smart_card_clock_divider.sv
`timescale 1ns/1ps
module smart_card_clock_divider (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ref_clock_in,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_cs_n,
    input wire logic address_select_pin,
    output logic card_clock_out,
    output logic card_reset_out,
    output logic slow_edge_setting,
    output logic fast_edge_setting
);
    logic [4:0] pins_s;
    logic ref_s, sclk_s, mosi_s, cs_n_s, asp_s;
    logic cs_sel_s;
    logic ref_d, sclk_d, cs_n_d;
    logic ref_rise, sclk_rise, cs_fall, cs_rise;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic addr_ok;
    logic [7:0] pend_byte;
    logic pend_valid;
    card_clock_pkg::ratio_t cfg_ratio;
    card_clock_pkg::ratio_t active;
    card_clock_pkg::ratio_t next_ratio;
    logic boundary;
    logic div_cnt;
    logic div_q;
    logic [2:0] lag_cnt;

    // Every pin is foreign to clk_sys and passes two flops first
    // Chip select crosses inverted so a cleared sync reads as idle, not as a false edge
    sync_two_stage #(.WIDTH(5)) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({ref_clock_in, spi_sclk, spi_mosi, ~spi_cs_n, address_select_pin}),
        .sync_out(pins_s)
    );
    assign {ref_s, sclk_s, mosi_s, cs_sel_s, asp_s} = pins_s;
    assign cs_n_s = ~cs_sel_s;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ref_d <= 1'b0;
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            ref_d <= ref_s;
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end
    assign ref_rise = ref_s & ~ref_d; // see RULE_02
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign cs_fall = ~cs_n_s & cs_n_d;
    assign cs_rise = cs_n_s & ~cs_n_d;

    // Serial command shifter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift <= card_clock_pkg::CMD_RESET;
            bit_cnt <= '0;
            addr_ok <= 1'b0;
            pend_byte <= card_clock_pkg::CMD_RESET;
            pend_valid <= 1'b0;
        end else if (cs_fall) begin
            shift <= card_clock_pkg::CMD_RESET;
            bit_cnt <= '0;
            addr_ok <= 1'b0;
            pend_valid <= 1'b0;
        end else if (sclk_rise) begin
            shift <= {shift[6:0], mosi_s}; // see RULE_11
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == card_clock_pkg::ADDR_DONE_CNT) begin
                addr_ok <= ({shift[1:0], mosi_s}
                    == {card_clock_pkg::ADDR_HIGH, asp_s}); // see RULE_11
            end
            if (bit_cnt == card_clock_pkg::BYTE_DONE_CNT && addr_ok) begin
                pend_byte <= {shift[6:0], mosi_s};
                pend_valid <= 1'b1;
            end
        end
    end

    // Settings change only as chip select rises
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_ratio <= card_clock_pkg::RATIO_OFF; // see RULE_12
            card_reset_out <= 1'b0;
            slow_edge_setting <= 1'b1;
            fast_edge_setting <= 1'b0;
        end else if (cs_rise && pend_valid) begin // see RULE_10
            cfg_ratio <= card_clock_pkg::ratio_t'(
                pend_byte[card_clock_pkg::RATIO_LSB +: 2]); // see RULE_09
            card_reset_out <= pend_byte[card_clock_pkg::RESET_BIT]; // see RULE_08
            slow_edge_setting <= ~pend_byte[card_clock_pkg::SLOPE_BIT]; // see RULE_07
            fast_edge_setting <= pend_byte[card_clock_pkg::SLOPE_BIT]; // see RULE_07
        end
    end

    // Ratio switches only with the last stage low, so no runt pulse reaches the card unless ratio 1 changes to off or quarter
    assign boundary = ~div_q & ~div_cnt;
    assign next_ratio = boundary ? cfg_ratio : active; // see RULE_05

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            active <= card_clock_pkg::RATIO_OFF;
            div_cnt <= 1'b0;
            div_q <= 1'b0;
        end else if (ref_rise) begin
            active <= next_ratio;
            case (next_ratio) // see RULE_01
                card_clock_pkg::RATIO_DIV2: begin
                    div_q <= ~div_q; // see RULE_04
                    div_cnt <= 1'b0;
                end
                card_clock_pkg::RATIO_DIV4: begin
                    div_cnt <= ~div_cnt;
                    if (div_cnt) begin
                        div_q <= ~div_q; // see RULE_04
                    end
                end
                default: begin
                    div_q <= 1'b0;
                    div_cnt <= 1'b0;
                end
            endcase
        end
    end

    // Ratio 1 copies the reference, so its duty is only as good as the input's
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            card_clock_out <= 1'b0; // see RULE_12
        end else if (active == card_clock_pkg::RATIO_DIV1) begin
            card_clock_out <= ref_s; // see RULE_06
        end else begin
            card_clock_out <= div_q; // see RULE_04
        end
    end

    // Helper: reference pulses since the requested ratio differs from the running one
    always_ff @(posedge clk_sys) begin
        if (srst || active == cfg_ratio) begin
            lag_cnt <= '0;
        end else if (ref_rise && lag_cnt != 3'h7) begin
            lag_cnt <= lag_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Checks on the divider and the card clock
    a_stop_low: assert property (active == card_clock_pkg::RATIO_OFF // see RULE_01
        |=> !card_clock_out)
        else $error("Card clock high while stopped");
    a_div1_follow: assert property (active == card_clock_pkg::RATIO_DIV1 // see RULE_06
        |=> card_clock_out == $past(ref_s))
        else $error("Ratio 1 output does not follow reference");
    a_div2_toggle: assert property (ref_rise && active == card_clock_pkg::RATIO_DIV2 // see RULE_04
        && cfg_ratio == card_clock_pkg::RATIO_DIV2 |=> div_q != $past(div_q))
        else $error("Half ratio stage missed a toggle");
    a_div4_hold: assert property (ref_rise && active == card_clock_pkg::RATIO_DIV4 // see RULE_04
        && cfg_ratio == card_clock_pkg::RATIO_DIV4 && !div_cnt
        |=> div_q == $past(div_q) && div_cnt)
        else $error("Quarter ratio stage toggled early");
    a_div4_toggle: assert property (ref_rise && active == card_clock_pkg::RATIO_DIV4 // see RULE_04
        && cfg_ratio == card_clock_pkg::RATIO_DIV4 && div_cnt
        |=> div_q != $past(div_q) && !div_cnt)
        else $error("Quarter ratio stage missed a toggle");
    a_out_stage: assert property (active != card_clock_pkg::RATIO_DIV1 // see RULE_04
        |=> card_clock_out == $past(div_q))
        else $error("Divided output not taken from the last stage");
    a_ratio_lag: assert property (lag_cnt <= 3'(card_clock_pkg::MAX_LAG_PULSES)) // see RULE_05
        else $error("Ratio change took more than four reference pulses");
    a_switch_edge: assert property (!$stable(active) // see RULE_05
        |-> $past(ref_rise) && $past(boundary))
        else $error("Ratio switched while the last stage was high");
    a_reset_low: assert property ($past(srst) // see RULE_12
        |-> !card_clock_out && cfg_ratio == card_clock_pkg::RATIO_OFF)
        else $error("Card clock not stopped after reset");

    // Checks on the serial port
    a_latch_cs: assert property (!$stable(cfg_ratio) |-> $past(cs_rise)) // see RULE_10
        else $error("Ratio changed without chip select rising");
    a_addr_reject: assert property (cs_rise && !pend_valid // see RULE_11
        |=> cfg_ratio == $past(cfg_ratio)
        && card_reset_out == $past(card_reset_out))
        else $error("Unaddressed command was applied");
    a_reset_bit: assert property (cs_rise && pend_valid // see RULE_08
        |=> card_reset_out == $past(pend_byte[card_clock_pkg::RESET_BIT]))
        else $error("Card reset does not follow bit b4");
    a_ratio_field: assert property (cs_rise && pend_valid // see RULE_09
        |=> cfg_ratio == $past(pend_byte[card_clock_pkg::RATIO_LSB +: 2]))
        else $error("Ratio does not follow bits b3 and b2");
    a_slope_field: assert property (cs_rise && pend_valid // see RULE_07
        |=> fast_edge_setting == $past(pend_byte[card_clock_pkg::SLOPE_BIT]))
        else $error("Slope does not follow bit b1");
    a_slope_pair: assert property (fast_edge_setting != slow_edge_setting) // see RULE_07
        else $error("Slope outputs not complementary");
    a_reset_hold: assert property (!$stable(card_reset_out) // see RULE_08
        |-> $past(cs_rise) && $past(pend_valid))
        else $error("Card reset changed without an applied command");
    a_pend_addr: assert property ($rose(pend_valid) |-> $past(addr_ok)) // see RULE_11
        else $error("Command accepted without a matching address");
    a_shift_msb: assert property (sclk_rise && !cs_fall // see RULE_11
        |=> shift[0] == $past(mosi_s) && shift[7:1] == $past(shift[6:0]))
        else $error("Serial bit not shifted in at the low end");
    a_cs_clear: assert property (cs_fall |=> !pend_valid && bit_cnt == 3'h0) // see RULE_10
        else $error("Chip select fall did not clear the shifter");
    a_idle_hold: assert property (cs_n_s // see RULE_10
        |=> $stable(bit_cnt) && $stable(pend_byte))
        else $error("Shifter moved while chip select was high");

    c_run_div1: cover property (active == card_clock_pkg::RATIO_DIV1 && card_clock_out);
    c_run_div2: cover property (active == card_clock_pkg::RATIO_DIV2 && $rose(card_clock_out));
    c_run_div4: cover property (active == card_clock_pkg::RATIO_DIV4 && $rose(card_clock_out));
    c_apply_cmd: cover property (cs_rise && pend_valid);
    c_reject_cmd: cover property (cs_rise && !pend_valid);
endmodule

// File: card_side_model.sv
`timescale 1ns/1ps
// Card side: measures how long the received clock stays high and low
module card_side_model (
    input wire logic clk_sys,
    input wire logic card_clock_out,
    output int high_len,
    output int low_len,
    output int run_len
);
    logic last;
    // Widths in system clocks; the card only listens and never drives back
    always_ff @(posedge clk_sys) begin
        last <= card_clock_out;
        if (card_clock_out == last) begin
            run_len <= run_len + 1;
        end else begin
            run_len <= 1;
            if (last) begin
                high_len <= run_len;
            end else begin
                low_len <= run_len;
            end
        end
    end
endmodule

// File: test_smart_card_clock_divider.sv
`timescale 1ns/1ps
module test_smart_card_clock_divider;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ref_clock_in = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_mosi = 1'b0;
    logic spi_cs_n = 1'b1;
    logic card_clock_out, card_reset_out, slow_edge_setting, fast_edge_setting;
    int bad_count = 0;
    int samples_checked = 0;
    int high_len, low_len, run_len;
    int ref_div = 0;
    int ref_hi = 5;
    int ref_lo = 5;
    logic address_select_pin = 1'b1;
    always #2.5 clk_sys = ~clk_sys;
    // Reference starts at 20 MHz so even the undivided ratio stays in the card's range
    always @(negedge clk_sys) begin
        if (ref_div >= (ref_clock_in ? ref_hi : ref_lo) - 1) begin
            ref_div <= 0;
            ref_clock_in <= ~ref_clock_in;
        end else begin
            ref_div <= ref_div + 1;
        end
    end
    smart_card_clock_divider i_dut (
        .clk_sys(clk_sys), .srst(srst), .ref_clock_in(ref_clock_in),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n),
        .address_select_pin(address_select_pin), .card_clock_out(card_clock_out),
        .card_reset_out(card_reset_out), .slow_edge_setting(slow_edge_setting),
        .fast_edge_setting(fast_edge_setting)
    );
    card_side_model i_card (
        .clk_sys(clk_sys), .card_clock_out(card_clock_out),
        .high_len(high_len), .low_len(low_len), .run_len(run_len)
    );
    task idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Levels held 3 clocks so the two-flop synchronisers see each one
    task shift(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = b[i];
            spi_sclk = 1'b0;
            idle(3);
            spi_sclk = 1'b1;
            idle(3);
        end
        spi_sclk = 1'b0;
    endtask
    task frame(input logic [7:0] b);
        spi_cs_n = 1'b0;
        idle(4);
        shift(b);
        idle(3);
        spi_cs_n = 1'b1;
        idle(8);
    endtask
    // Waits out the ratio lag before judging the waveform
    task check_clock(input card_clock_pkg::ratio_t r);
        int half;
        idle(120);
        half = ref_hi + ref_lo;
        if (r == card_clock_pkg::RATIO_DIV1) begin
            half = half / 2;
        end else if (r == card_clock_pkg::RATIO_DIV4) begin
            half = 2 * half;
        end
        if (r == card_clock_pkg::RATIO_OFF) begin
            chk(card_clock_out, 1'b0);
            chk(run_len >= 40, 1'b1);
        end else begin
            chk(high_len, half);
            chk(low_len, half);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #50us;
        bad_count++;
        stop_test();
    end
    initial begin
        logic [1:0] k;
        idle(3);
        srst = 1'b0;
        idle(3);
        chk({card_clock_out, card_reset_out, slow_edge_setting, fast_edge_setting},
            4'h2);
        check_clock(card_clock_pkg::RATIO_OFF);
        $display("test reset done");
        for (int i = 3; i >= 0; i--) begin
            k = i[1:0];
            frame({3'h1, k[0], k, ~k[0], 1'b0});
            chk({card_reset_out, slow_edge_setting, fast_edge_setting},
                {k[0], k[0], ~k[0]});
            check_clock(card_clock_pkg::ratio_t'(k));
        end
        $display("test ratios done");
        frame(8'h1A);
        chk(card_reset_out, 1'b0);
        check_clock(card_clock_pkg::RATIO_OFF);
        $display("test wrong address done");
        // Same byte again, now addressed to this chip through the select pin
        address_select_pin = 1'b0;
        spi_cs_n = 1'b0;
        idle(4);
        shift(8'h1A);
        idle(20);
        chk(card_reset_out, 1'b0);
        spi_cs_n = 1'b1;
        idle(8);
        chk({card_reset_out, fast_edge_setting}, 2'h3);
        check_clock(card_clock_pkg::RATIO_DIV2);
        $display("test late latch done");
        // Reference at 40 MHz with an uneven duty; divided outputs must still be even
        ref_hi = 3;
        ref_lo = 2;
        check_clock(card_clock_pkg::RATIO_DIV2);
        frame(8'h1E);
        chk({card_reset_out, fast_edge_setting}, 2'h3);
        check_clock(card_clock_pkg::RATIO_DIV4);
        $display("test fast reference done");
        srst = 1'b1;
        idle(3);
        srst = 1'b0;
        idle(3);
        chk({card_clock_out, card_reset_out, slow_edge_setting, fast_edge_setting},
            4'h2);
        check_clock(card_clock_pkg::RATIO_OFF);
        $display("test second reset done");
        stop_test();
    end
endmodule
